// ===== hw/sdpc_pkg.sv
// Purpose: Shared constants for the synthesizer divider and power configuration link.
// Assumes: 24-bit programming words, shifted MSB first, latched on the rising edge of the latch line.
// Notes:   Field positions follow the programming word layout; host register offsets are local.
package sdpc_pkg;
    localparam int WORD_W = 24;
    // Word type codes in the low bits of each programming word.
    localparam logic       CODE_MAIN = 1'b0;
    localparam logic [3:0] CODE_REF  = 4'h3;
    localparam logic [3:0] CODE_AUX  = 4'h5;
    // Field positions.
    localparam int SLEEP_POS   = 23;
    localparam int MODSEL_POS  = 22;
    localparam int REF_LSB     = 16;
    localparam int REF_W       = 6;
    localparam int FD_LSB      = 4;
    localparam int FD_W        = 12;
    localparam int MAIN_LSB    = 13;
    localparam int MAIN_W      = 11;
    localparam int AUX_LSB     = 4;
    localparam int AUX_W       = 19;
    localparam int DIV_W       = 12;
    // Prescaler base moduli.
    localparam logic [DIV_W-1:0] BASE_LOW  = 12'h010;
    localparam logic [DIV_W-1:0] BASE_HIGH = 12'h020;
    // Reset values of the device settings.
    localparam logic [REF_W-1:0] RST_REF   = 6'h01;
    localparam logic             RST_SLEEP = 1'b1;
    // Host register offsets and configuration bits.
    localparam logic [3:0] ADDR_CFG    = 4'h0;
    localparam logic [3:0] ADDR_RF_DIV = 4'h1;
    localparam logic [3:0] ADDR_RF_REF = 4'h2;
    localparam logic [3:0] ADDR_IF_DIV = 4'h3;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam int CFG_MODSEL   = 0;
    localparam int CFG_ORD_LSB  = 1;
    localparam int CFG_RF_SLEEP = 3;
    localparam int CFG_IF_SLEEP = 4;
    localparam int CFG_W        = 5;
    localparam int ST_BUSY      = 0;
    localparam int ST_REFUSED   = 1;
    // Serial timing: the link is rated to 20 MHz, so each half period lasts at least 25 ns.
    localparam int CLK_NS      = 20;
    localparam int SER_HALF_NS = 25;
    localparam int SER_HALF_CYC = (SER_HALF_NS + CLK_NS - 1) / CLK_NS;
    typedef enum logic [1:0] {ORD_2, ORD_3, ORD_4} sdpc_order_e;
endpackage

// ===== hw/sdpc_link_if.sv
// Purpose: Three-wire programming link between the host controller and the synthesizer.
// Assumes: The host drives every line; the device only listens.
// Notes:   No clocking block; both ends sample on their own system clock.
`timescale 1ns/1ps
interface sdpc_link_if;
    logic ser_clk;
    logic ser_data;
    logic ser_le;
    modport host (output ser_clk, output ser_data, output ser_le);
    modport dev  (input ser_clk, input ser_data, input ser_le);
endinterface

// ===== hw/sdpc_dev.sv
// Purpose: Synthesizer end: receives programming words and holds divider and power settings.
// Assumes: Link lines and the chip enable pin are asynchronous and are synchronised first.
// Notes:   Words with an unknown type code are ignored.
`timescale 1ns/1ps
module sdpc_dev (
    input  wire logic        sys_clk_i,
    input  wire logic        srst_i,
    sdpc_link_if.dev         link,
    input  wire logic        chip_enable_i,
    input  wire logic        auto_wake_bit_i,
    output logic [11:0]      rf_main_divisor_o,
    output logic [5:0]       rf_reference_divisor_o,
    output logic             rf_modulus_select_o,
    output logic             rf_powered_o,
    output logic             rf_cp_hiz_o,
    output logic [18:0]      aux_divisor_o,
    output logic             aux_sleep_bit_o
);
    // Two-flop synchronisers for clock, data, latch and chip enable.
    logic [3:0] pin_raw;
    logic [3:0] meta_reg;
    logic [3:0] sync_reg;
    assign pin_raw = {chip_enable_i, link.ser_le, link.ser_data, link.ser_clk};
    for (genvar i = 0; i < 4; i++) begin : g_sync
        always_ff @(posedge sys_clk_i) begin
            if (srst_i) begin
                meta_reg[i] <= 1'b0;
                sync_reg[i] <= 1'b0;
            end else begin
                meta_reg[i] <= pin_raw[i];
                sync_reg[i] <= meta_reg[i];
            end
        end
    end

    logic                          clk_old_reg;
    logic                          le_old_reg;
    logic [sdpc_pkg::WORD_W-1:0]   shift_reg;
    logic [sdpc_pkg::MAIN_W-1:0]   main_field_reg;
    logic [sdpc_pkg::REF_W-1:0]    ref_reg;
    logic                          modsel_reg;
    logic                          rf_sleep_reg;
    logic [sdpc_pkg::AUX_W-1:0]    aux_reg;
    logic                          aux_sleep_reg;

    // Edge and word decode.
    wire clk_rise = sync_reg[0] & ~clk_old_reg;
    wire le_rise  = sync_reg[2] & ~le_old_reg;
    wire is_main  = le_rise & (shift_reg[0] == sdpc_pkg::CODE_MAIN);
    wire is_ref   = le_rise & (shift_reg[3:0] == sdpc_pkg::CODE_REF);
    wire is_aux   = le_rise & (shift_reg[3:0] == sdpc_pkg::CODE_AUX);
    wire [sdpc_pkg::REF_W-1:0] ref_field = shift_reg[sdpc_pkg::REF_LSB +: sdpc_pkg::REF_W];
    wire ref_ok   = ref_field != '0;

    // Main divide value from coarse, middle and fine counts.
    wire [5:0] coarse = main_field_reg[10:5];
    wire [2:0] middle = modsel_reg ? main_field_reg[4:2] : {1'b0, main_field_reg[3:2]};
    wire [1:0] fine   = main_field_reg[1:0];
    wire [11:0] base  = modsel_reg ? sdpc_pkg::BASE_HIGH : sdpc_pkg::BASE_LOW;
    wire [11:0] coarse_lo = {2'b00, coarse, 4'h0};
    wire [11:0] coarse_hi = {1'b0, coarse, 5'h00};
    wire [11:0] main_next = (base == sdpc_pkg::BASE_HIGH ? coarse_hi : coarse_lo)
                            + {7'h00, middle, 2'b00} + {10'h000, fine};

    // Power precedence: enable pin, then auto wake, then sleep bit.
    wire powered_next = sync_reg[3] & (auto_wake_bit_i | ~rf_sleep_reg);

    // Shift register and edge history.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            clk_old_reg <= 1'b0;
            le_old_reg  <= 1'b0;
            shift_reg   <= '0;
        end else begin
            clk_old_reg <= sync_reg[0];
            le_old_reg  <= sync_reg[2];
            if (clk_rise) begin
                shift_reg <= {shift_reg[sdpc_pkg::WORD_W-2:0], sync_reg[1]};
            end
        end
    end

    // Settings update on a latched word; a zero reference divisor keeps the old one.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            main_field_reg <= '0;
            ref_reg        <= sdpc_pkg::RST_REF;
            modsel_reg     <= 1'b0;
            rf_sleep_reg   <= sdpc_pkg::RST_SLEEP;
            aux_reg        <= '0;
            aux_sleep_reg  <= sdpc_pkg::RST_SLEEP;
        end else begin
            if (is_main) begin
                main_field_reg <= shift_reg[sdpc_pkg::MAIN_LSB +: sdpc_pkg::MAIN_W];
            end
            if (is_ref) begin
                modsel_reg   <= shift_reg[sdpc_pkg::MODSEL_POS];
                rf_sleep_reg <= shift_reg[sdpc_pkg::SLEEP_POS];
                if (ref_ok) begin
                    ref_reg <= ref_field;
                end
            end
            if (is_aux) begin
                aux_reg       <= shift_reg[sdpc_pkg::AUX_LSB +: sdpc_pkg::AUX_W];
                aux_sleep_reg <= shift_reg[sdpc_pkg::SLEEP_POS];
            end
        end
    end

    // Registered outputs; the charge pump floats whenever the RF side sleeps.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            rf_main_divisor_o      <= '0;
            rf_reference_divisor_o <= sdpc_pkg::RST_REF;
            rf_modulus_select_o    <= 1'b0;
            rf_powered_o           <= 1'b0;
            rf_cp_hiz_o            <= 1'b1;
            aux_divisor_o          <= '0;
            aux_sleep_bit_o        <= sdpc_pkg::RST_SLEEP;
        end else begin
            rf_main_divisor_o      <= main_next;
            rf_reference_divisor_o <= ref_reg;
            rf_modulus_select_o    <= modsel_reg;
            rf_powered_o           <= powered_next;
            rf_cp_hiz_o            <= ~powered_next;
            aux_divisor_o          <= aux_reg;
            aux_sleep_bit_o        <= aux_sleep_reg;
        end
    end
endmodule // sdpc_dev

// ===== hw/sdpc_host.sv
// Purpose: Host end: takes software orders, checks divide values and shifts out programming words.
// Assumes: Software port with one-cycle strobes; read data in the cycle after the read strobe.
// Notes:   Illegal or busy-time divider writes are dropped and flagged; nothing is sent for them.
`timescale 1ns/1ps
module sdpc_host #(
    parameter int HALF_CYC = sdpc_pkg::SER_HALF_CYC
) (
    input  wire logic        sys_clk_i,
    input  wire logic        srst_i,
    sdpc_link_if.host        link,
    input  wire logic [3:0]  addr_i,
    input  wire logic [31:0] wr_data_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic [31:0]      rd_data_o
);
    if (HALF_CYC < 1 || HALF_CYC > 255) begin : g_bad_half
        $error("HALF_CYC must lie in 1..255");
    end

    localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);
    localparam logic [4:0] BIT_LAST  = 5'(sdpc_pkg::WORD_W - 1);

    typedef enum logic [1:0] {S_IDLE, S_LOW, S_HIGH, S_LATCH} sdpc_ser_e;

    // Inclusive range test shared by the legality checks.
    function automatic logic in_rng(input logic [18:0] v, input logic [18:0] lo, input logic [18:0] hi);
        in_rng = (v >= lo) && (v <= hi);
    endfunction

    // Legal RF divide values per prescaler and modulator order.
    function automatic logic rf_legal(input logic [18:0] n, input logic hi_pre,
                                      input sdpc_pkg::sdpc_order_e ord);
        logic ok;
        ok = 1'b0;
        if (hi_pre) begin
            case (ord)
                sdpc_pkg::ORD_2: ok = in_rng(n, 19'd97, 19'd109) | in_rng(n, 19'd129, 19'd145)
                                    | in_rng(n, 19'd161, 19'd181) | in_rng(n, 19'd193, 19'd217)
                                    | in_rng(n, 19'd225, 19'd2045);
                sdpc_pkg::ORD_3: ok = in_rng(n, 19'd99, 19'd107) | in_rng(n, 19'd131, 19'd143)
                                    | in_rng(n, 19'd163, 19'd179) | in_rng(n, 19'd195, 19'd215)
                                    | in_rng(n, 19'd227, 19'd2043);
                sdpc_pkg::ORD_4: ok = (n == 19'd103) | in_rng(n, 19'd135, 19'd139)
                                    | in_rng(n, 19'd167, 19'd175) | in_rng(n, 19'd199, 19'd211)
                                    | in_rng(n, 19'd231, 19'd2039);
                default:         ok = 1'b0;
            endcase
        end else begin
            case (ord)
                sdpc_pkg::ORD_2: ok = in_rng(n, 19'd49, 19'd61) | in_rng(n, 19'd64, 19'd1023);
                sdpc_pkg::ORD_3: ok = in_rng(n, 19'd51, 19'd59) | in_rng(n, 19'd64, 19'd1023);
                sdpc_pkg::ORD_4: ok = (n == 19'd55) | in_rng(n, 19'd64, 19'd75)
                                    | in_rng(n, 19'd80, 19'd1023);
                default:         ok = 1'b0;
            endcase
        end
        rf_legal = ok;
    endfunction

    // Legal IF divide values with the low-modulus prescaler.
    function automatic logic if_legal(input logic [18:0] n);
        if_legal = in_rng(n, 19'd24, 19'd27) | in_rng(n, 19'd32, 19'd36)
                 | in_rng(n, 19'd40, 19'd45) | in_rng(n, 19'd48, 19'd54)
                 | in_rng(n, 19'd56, 19'd262143);
    endfunction

    logic [sdpc_pkg::CFG_W-1:0]  cfg_reg;
    logic [10:0]                 rf_div_reg;
    logic [sdpc_pkg::REF_W-1:0]  ref_reg;
    logic [sdpc_pkg::FD_W-1:0]   fd_reg;
    logic [18:0]                 if_div_reg;
    logic                        refused_reg;
    logic [31:0]                 rd_data_next;
    sdpc_ser_e                   state_reg;
    sdpc_ser_e                   state_next;
    logic [7:0]                  cnt_reg;
    logic [4:0]                  bit_reg;
    logic [sdpc_pkg::WORD_W-1:0] shift_reg;
    logic                        ser_clk_reg;
    logic                        ser_data_reg;
    logic                        ser_le_reg;

    // Register decode and the candidate words for each order.
    wire busy     = state_reg != S_IDLE;
    wire hi_pre   = cfg_reg[sdpc_pkg::CFG_MODSEL];
    wire sdpc_pkg::sdpc_order_e order = sdpc_pkg::sdpc_order_e'(cfg_reg[sdpc_pkg::CFG_ORD_LSB +: 2]);
    wire wr_cfg   = wr_i & (addr_i == sdpc_pkg::ADDR_CFG);
    wire wr_rf    = wr_i & (addr_i == sdpc_pkg::ADDR_RF_DIV);
    wire wr_ref   = wr_i & (addr_i == sdpc_pkg::ADDR_RF_REF);
    wire wr_if    = wr_i & (addr_i == sdpc_pkg::ADDR_IF_DIV);
    wire wr_stat  = wr_i & (addr_i == sdpc_pkg::ADDR_STATUS);
    wire [18:0] rf_n  = {8'h00, wr_data_i[10:0]};
    wire [18:0] if_n  = wr_data_i[18:0];
    wire rf_ok    = rf_legal(rf_n, hi_pre, order) && (wr_data_i[31:11] == '0);
    wire ref_ok   = wr_data_i[5:0] != '0;
    wire if_ok    = if_legal(if_n) && (wr_data_i[31:19] == '0);
    wire go_rf    = wr_rf & ~busy & rf_ok;
    wire go_ref   = wr_ref & ~busy & ref_ok;
    wire go_if    = wr_if & ~busy & if_ok;
    wire start    = go_rf | go_ref | go_if;
    wire refuse   = (wr_rf & ~go_rf) | (wr_ref & ~go_ref) | (wr_if & ~go_if);

    // Coarse, middle and fine counts from the divide value.
    wire [5:0] coarse = hi_pre ? wr_data_i[10:5] : wr_data_i[9:4];
    wire [2:0] middle = hi_pre ? wr_data_i[4:2] : {1'b0, wr_data_i[3:2]};
    wire [10:0] main_field = {coarse, middle, wr_data_i[1:0]};
    wire [23:0] word_main = {main_field, 12'h000, sdpc_pkg::CODE_MAIN};
    wire [23:0] word_ref  = {cfg_reg[sdpc_pkg::CFG_RF_SLEEP], hi_pre, wr_data_i[5:0],
                             wr_data_i[17:6], sdpc_pkg::CODE_REF};
    wire [23:0] word_aux  = {cfg_reg[sdpc_pkg::CFG_IF_SLEEP], if_n, sdpc_pkg::CODE_AUX};
    wire [23:0] word_sel  = go_rf ? word_main : (go_ref ? word_ref : word_aux);
    wire half_done = cnt_reg == HALF_LAST;

    // Read mux, answered in the next cycle.
    always_comb begin
        rd_data_next = 32'h0000_0000;
        case (addr_i)
            sdpc_pkg::ADDR_CFG:    rd_data_next = {27'h0, cfg_reg};
            sdpc_pkg::ADDR_RF_DIV: rd_data_next = {21'h0, rf_div_reg};
            sdpc_pkg::ADDR_RF_REF: rd_data_next = {14'h0, fd_reg, ref_reg};
            sdpc_pkg::ADDR_IF_DIV: rd_data_next = {13'h0, if_div_reg};
            sdpc_pkg::ADDR_STATUS: rd_data_next = {30'h0, refused_reg, busy};
            default:               rd_data_next = 32'h0000_0000;
        endcase
    end

    // Serializer sequencing: low half, high half per bit, then a latch pulse.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            S_IDLE:  if (start) state_next = S_LOW;
            S_LOW:   if (half_done) state_next = S_HIGH;
            S_HIGH:  if (half_done) state_next = (bit_reg == BIT_LAST) ? S_LATCH : S_LOW;
            S_LATCH: if (half_done) state_next = S_IDLE;
            default: state_next = S_IDLE;
        endcase
    end

    // Software registers; a refusal in the same cycle as a clear keeps the flag set.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            cfg_reg     <= '0;
            rf_div_reg  <= '0;
            ref_reg     <= sdpc_pkg::RST_REF;
            fd_reg      <= '0;
            if_div_reg  <= '0;
            refused_reg <= 1'b0;
            rd_data_o   <= '0;
        end else begin
            if (wr_cfg) cfg_reg <= wr_data_i[sdpc_pkg::CFG_W-1:0];
            if (go_rf) rf_div_reg <= wr_data_i[10:0];
            if (go_ref) ref_reg <= wr_data_i[5:0];
            if (go_ref) fd_reg <= wr_data_i[17:6];
            if (go_if) if_div_reg <= if_n;
            if (refuse) refused_reg <= 1'b1;
            else if (wr_stat & wr_data_i[sdpc_pkg::ST_REFUSED]) refused_reg <= 1'b0;
            rd_data_o <= rd_i ? rd_data_next : 32'h0000_0000;
        end
    end

    // Link pins, MSB first; data changes while the clock is low.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            state_reg    <= S_IDLE;
            cnt_reg      <= '0;
            bit_reg      <= '0;
            shift_reg    <= '0;
            ser_clk_reg  <= 1'b0;
            ser_data_reg <= 1'b0;
            ser_le_reg   <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= (state_reg == S_IDLE || half_done) ? 8'h00 : cnt_reg + 8'h01;
            if (state_reg == S_IDLE && start) begin
                shift_reg    <= word_sel;
                ser_data_reg <= word_sel[23];
                bit_reg      <= '0;
            end
            if (state_reg == S_LOW && half_done) ser_clk_reg <= 1'b1;
            if (state_reg == S_HIGH && half_done) begin
                ser_clk_reg <= 1'b0;
                if (bit_reg == BIT_LAST) begin
                    ser_le_reg <= 1'b1;
                end else begin
                    shift_reg    <= {shift_reg[22:0], 1'b0};
                    ser_data_reg <= shift_reg[22];
                    bit_reg      <= bit_reg + 5'h01;
                end
            end
            if (state_reg == S_LATCH && half_done) ser_le_reg <= 1'b0;
        end
    end

    assign link.ser_clk  = ser_clk_reg;
    assign link.ser_data = ser_data_reg;
    assign link.ser_le   = ser_le_reg;
endmodule // sdpc_host

// ===== sim/sdpc_props.sv
// Purpose: Concurrent checks on the programming link and the synthesizer end.
// Assumes: One clock domain; the latch pulse and clock levels last HALF_CYC cycles.
// Notes:   Instantiated in tb beside the link interface; no bind.
`timescale 1ns/1ps
module sdpc_props #(
    parameter int HALF_CYC = 2
) (
    input  wire logic        sys_clk_i,
    input  wire logic        srst_i,
    input  wire logic        ser_clk,
    input  wire logic        ser_data,
    input  wire logic        ser_le,
    input  wire logic        chip_enable_i,
    input  wire logic        auto_wake_bit_i,
    input  wire logic [11:0] rf_main_divisor_o,
    input  wire logic [5:0]  rf_reference_divisor_o,
    input  wire logic        rf_modulus_select_o,
    input  wire logic        rf_powered_o,
    input  wire logic        rf_cp_hiz_o,
    input  wire logic [18:0] aux_divisor_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);
    logic [3:0] le_age_reg;
    logic [3:0] le_run_reg;
    logic [3:0] clk_run_reg;
    logic       clk_q_reg;

    // Latch age and level run lengths; latch age and clock run saturate, latch run wraps, since only short spans matter.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            le_age_reg  <= 4'hf;
            le_run_reg  <= 4'h0;
            clk_run_reg <= 4'hf;
            clk_q_reg   <= 1'b0;
        end else begin
            le_age_reg  <= ser_le ? 4'h0 : le_age_reg + {3'h0, le_age_reg != 4'hf};
            le_run_reg  <= ser_le ? le_run_reg + 4'h1 : 4'h0;
            clk_run_reg <= (ser_clk != clk_q_reg) ? 4'h1 : clk_run_reg + {3'h0, clk_run_reg != 4'hf};
            clk_q_reg   <= ser_clk;
        end
    end

    // A short clock level would outrun the device synchronisers.
    clk_half_a: assert property ((ser_clk != clk_q_reg) |-> clk_run_reg >= HALF_CYC)
        else $error("serial clock level shorter than half period");
    le_width_a: assert property ($fell(ser_le) |-> le_run_reg == HALF_CYC)
        else $error("latch pulse width wrong");
    le_idle_a: assert property (ser_le |-> !ser_clk)
        else $error("latch raised while serial clock high");
    data_hold_a: assert property ($changed(ser_data) |-> !ser_clk)
        else $error("serial data moved while clock high");
    hiz_track_a: assert property (rf_cp_hiz_o == !rf_powered_o)
        else $error("charge pump float does not follow power state");
    ce_low_a: assert property ((!chip_enable_i) [*4] |-> !rf_powered_o)
        else $error("powered while enable pin low");
    wake_up_a: assert property ((chip_enable_i && auto_wake_bit_i) [*5] |-> rf_powered_o)
        else $error("auto wake did not power up");
    ref_range_a: assert property (rf_reference_divisor_o != 6'h00)
        else $error("reference divisor zero");
    div_latch_a: assert property (($changed(rf_main_divisor_o) || $changed(rf_modulus_select_o))
        |-> le_age_reg < 4'h8)
        else $error("divider setting changed without a latch");
    aux_latch_a: assert property ($changed(aux_divisor_o) |-> le_age_reg < 4'h8)
        else $error("aux divisor changed without a latch");

    cover property ($rose(ser_le));
    cover property ($rose(rf_powered_o));
    cover property ($fell(rf_powered_o));
endmodule // sdpc_props

// ===== sim/tb.sv
// Purpose: Self-checking bench for the host and synthesizer ends joined by the link.
// Assumes: Register port with one-cycle strobes; default serial half period.
// Notes:   An integer model of the device settings is compared after every transfer.
`timescale 1ns/1ps
module tb;
    localparam int HC = 2;
    logic        sys_clk_i;
    logic        srst_i;
    logic [3:0]  addr_i;
    logic [31:0] wr_data_i;
    logic        wr_i;
    logic        rd_i;
    logic [31:0] rd_data_o;
    logic        chip_enable_i;
    logic        auto_wake_bit_i;
    logic [11:0] rf_main_divisor_o;
    logic [5:0]  rf_reference_divisor_o;
    logic        rf_modulus_select_o;
    logic        rf_powered_o;
    logic        rf_cp_hiz_o;
    logic [18:0] aux_divisor_o;
    logic        aux_sleep_bit_o;
    logic [31:0] st;
    int          fails;
    int          comparisons;
    int          m_main, m_ref, m_mod, m_aux, m_asl, m_sl, n;
    bit          ok;
    int          nt[24] = '{48, 49, 55, 61, 64, 75, 80, 96, 97, 103, 109, 110, 225, 227, 230, 231,
                            1023, 1024, 2039, 2040, 2043, 2044, 2045, 2046};
    int          it[15] = '{23, 24, 27, 28, 31, 32, 36, 37, 45, 48, 54, 55, 56, 262143, 262144};
    int          rt[8]  = '{1, 63, 7, 12, 33, 0, 2, 63};

    sdpc_link_if link_if ();
    sdpc_host #(.HALF_CYC(HC)) i_sdpc_host (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .link(link_if),
        .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o));
    sdpc_dev i_sdpc_dev (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .link(link_if),
        .chip_enable_i(chip_enable_i), .auto_wake_bit_i(auto_wake_bit_i),
        .rf_main_divisor_o(rf_main_divisor_o), .rf_reference_divisor_o(rf_reference_divisor_o),
        .rf_modulus_select_o(rf_modulus_select_o), .rf_powered_o(rf_powered_o), .rf_cp_hiz_o(rf_cp_hiz_o),
        .aux_divisor_o(aux_divisor_o), .aux_sleep_bit_o(aux_sleep_bit_o));
    sdpc_props #(.HALF_CYC(HC)) u_props (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
        .ser_clk(link_if.ser_clk), .ser_data(link_if.ser_data), .ser_le(link_if.ser_le),
        .chip_enable_i(chip_enable_i), .auto_wake_bit_i(auto_wake_bit_i),
        .rf_main_divisor_o(rf_main_divisor_o), .rf_reference_divisor_o(rf_reference_divisor_o),
        .rf_modulus_select_o(rf_modulus_select_o), .rf_powered_o(rf_powered_o), .rf_cp_hiz_o(rf_cp_hiz_o),
        .aux_divisor_o(aux_divisor_o));

    // System clock, 20 ns period.
    initial begin
        sys_clk_i = 1'b0;
        forever #10 sys_clk_i = ~sys_clk_i;
    end

    task automatic finish_test();
        if (fails == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // One-cycle strobes, launched right after an edge so the host samples them on the next one.
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        wr_i      <= 1'b1;
        addr_i    <= a;
        wr_data_i <= d;
        @(posedge sys_clk_i);
        wr_i      <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe is taken, so sample just past that edge.
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge sys_clk_i);
        rd_i   <= 1'b0;
        #1 d = rd_data_o;
    endtask

    // Compare every device output with the model; m_main is the count field last sent.
    task automatic chk_dev();
        chk("main", (m_mod ? 32 : 16) * (m_main >> 5) + (m_main & 31), {20'h0, rf_main_divisor_o});
        chk("ref", m_ref, {26'h0, rf_reference_divisor_o});
        chk("modsel", m_mod, {31'h0, rf_modulus_select_o});
        chk("powered", chip_enable_i && (auto_wake_bit_i || m_sl == 0), {31'h0, rf_powered_o});
        chk("cp_hiz", !(chip_enable_i && (auto_wake_bit_i || m_sl == 0)), {31'h0, rf_cp_hiz_o});
        chk("aux", m_aux, {13'h0, aux_divisor_o});
        chk("aux_sleep", m_asl, {31'h0, aux_sleep_bit_o});
    endtask

    // Write one divide word, check the refusal flag, then wait for the link and compare.
    task automatic send(input logic [3:0] a, input logic [31:0] d, input bit good);
        logic [31:0] s;
        int          i;
        wr(a, d);
        rd(sdpc_pkg::ADDR_STATUS, s);
        chk("refused", {31'h0, !good}, {31'h0, s[sdpc_pkg::ST_REFUSED]});
        if (!good) begin
            wr(sdpc_pkg::ADDR_STATUS, 32'h2);
        end
        s = 32'h1;
        for (i = 0; i < 300 && s[sdpc_pkg::ST_BUSY] !== 1'b0; i++) rd(sdpc_pkg::ADDR_STATUS, s);
        if (s[sdpc_pkg::ST_BUSY] !== 1'b0) begin
            fails++;
            finish_test();
        end
        repeat (8) @(posedge sys_clk_i);
        chk_dev();
    endtask

    function automatic bit inr(int v, int lo, int hi);
        return v >= lo && v <= hi;
    endfunction

    // Legal main divide values by prescaler and modulator order (3 means none legal).
    function automatic bit rf_ok(int v, int hi, int o);
        if (o == 3) return 1'b0;
        if (hi == 0) return (o == 2) ? (v == 55 || inr(v, 64, 75) || inr(v, 80, 1023))
                                     : (inr(v, 49 + 2 * o, 61 - 2 * o) || inr(v, 64, 1023));
        if (o == 0) return inr(v, 97, 109) || inr(v, 129, 145) || inr(v, 161, 181) || inr(v, 193, 217)
                           || inr(v, 225, 2045);
        if (o == 1) return inr(v, 99, 107) || inr(v, 131, 143) || inr(v, 163, 179) || inr(v, 195, 215)
                           || inr(v, 227, 2043);
        return v == 103 || inr(v, 135, 139) || inr(v, 167, 175) || inr(v, 199, 211) || inr(v, 231, 2039);
    endfunction

    // Main sequence: reset values, divider sweep, power precedence, aux divisor, busy refusal.
    initial begin
        srst_i = 1'b1;
        addr_i = 4'h0;
        wr_data_i = 32'h0;
        wr_i = 1'b0;
        rd_i = 1'b0;
        chip_enable_i = 1'b1;
        auto_wake_bit_i = 1'b0;
        fails = 0;
        comparisons = 0;
        {m_main, m_ref, m_mod, m_aux, m_asl, m_sl} = {32'd0, 32'd1, 32'd0, 32'd0, 32'd1, 32'd1};
        repeat (12) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        void'($urandom(95737));
        repeat (4) @(posedge sys_clk_i);
        chk_dev();
        for (int hi = 0; hi < 2; hi++) begin
            wr(sdpc_pkg::ADDR_CFG, hi);
            {m_mod, m_sl, m_ref} = {hi, 32'd0, 32'd1 + $urandom % 63};
            send(sdpc_pkg::ADDR_RF_REF, m_ref | (($urandom % 4096) << 6), 1'b1);
            for (int o = 0; o < 4; o++) begin
                wr(sdpc_pkg::ADDR_CFG, hi | (o << 1));
                for (int k = 0; k < 27; k++) begin
                    n = (k < 24) ? nt[k] : 97 + int'($urandom % 150);
                    ok = rf_ok(n, hi, o);
                    if (ok) m_main = hi ? n : ((n >> 4) << 5) | (n & 15);
                    send(sdpc_pkg::ADDR_RF_DIV, n, ok);
                end
            end
        end
        for (int i = 0; i < 8; i++) begin
            chip_enable_i   <= i[2];
            auto_wake_bit_i <= i[1];
            wr(sdpc_pkg::ADDR_CFG, (i[0] << 3) | 1);
            if (rt[i] != 0) {m_ref, m_mod, m_sl} = {rt[i], 32'd1, i & 1};
            send(sdpc_pkg::ADDR_RF_REF, rt[i], rt[i] != 0);
        end
        for (int k = 0; k < 15; k++) begin
            wr(sdpc_pkg::ADDR_CFG, ((k & 1) << 4) | 1);
            n = it[k];
            ok = inr(n, 24, 27) || inr(n, 32, 36) || inr(n, 40, 45) || inr(n, 48, 54) || inr(n, 56, 262143);
            if (ok) {m_aux, m_asl} = {n, k & 1};
            send(sdpc_pkg::ADDR_IF_DIV, n, ok);
        end
        m_main = 500;
        wr(sdpc_pkg::ADDR_RF_DIV, 32'd500);
        send(sdpc_pkg::ADDR_RF_DIV, 32'd600, 1'b0);
        rd(4'h9, st);
        chk("unmapped", 32'h0, st);
        rd(sdpc_pkg::ADDR_RF_DIV, st);
        chk("rf_div", 32'd500, st);
        finish_test();
    end
endmodule // tb
